// File: amp_link_defs.svh
// constants shared by both ends of the amplifier status link
`ifndef AMP_LINK_DEFS_SVH
`define AMP_LINK_DEFS_SVH
// target address and direction
`define TGT_ADDR7        7'h6c
`define DIR_WRITE        1'b0
`define DIR_READ         1'b1
// register indices
`define IDX_FAULTS       8'h01
`define IDX_STATE        8'h02
// reserved low bits and bit counts
`define RSVD_BITS        2'b00
`define BYTE_BITS        4'h8
`define LAST_TX_BIT      4'h7
// serial clock timing
`define CORE_PERIOD_PS   5000
`define SCL_PERIOD_PS    2500000
`define QTR_CYCLES       (`SCL_PERIOD_PS / (4 * `CORE_PERIOD_PS))
// controller registers on the AXI4-Lite side
`define CTRL_OFS         4'h0
`define STATUS_OFS       4'h4
`define CTRL_GO_BIT      0
`define CTRL_RW_BIT      1
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// File: amp_link_pkg.sv
// types shared by both ends of the amplifier status link
package amp_link_pkg;
   typedef enum logic [2:0] {
      T_IDLE = 3'b000,
      T_RX   = 3'b001,
      T_RACK = 3'b010,
      T_TX   = 3'b011,
      T_TACK = 3'b100
   } tgt_state_type;
   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_START = 3'b001,
      H_TXB   = 3'b010,
      H_RXB   = 3'b011,
      H_STOP  = 3'b100
   } host_op_type;
endpackage : amp_link_pkg

// File: amp_link_if.sv
// two-wire link joining the controller and the amplifier target
`timescale 1ns/1ps
`default_nettype none
interface amp_link_if;
   logic host_scl_out;
   logic host_scl_oe;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic scl;
   logic sda;
   // open-drain resolution with pull-ups
   assign scl = host_scl_oe ? host_scl_out : 1'b1;
   assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);
   modport target_mp (input scl, input sda, output dev_sda_out, output dev_sda_oe);
   modport host_mp (input scl, input sda, output host_scl_out, output host_scl_oe,
                    output host_sda_out, output host_sda_oe);
endinterface : amp_link_if
`default_nettype wire

// File: amp_status_target.sv
// amplifier two-wire target with latched fault and state registers
`timescale 1ns/1ps
`default_nettype none
`include "amp_link_defs.svh"
module amp_status_target (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_N_I,
   amp_link_if.target_mp    LINK,
   input  wire logic [5:0]  FAULT_EVENT_I,
   input  wire logic [5:0]  STATE_LIVE_I,
   output logic             FAULT_N_O
);
   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   logic [2:0]                 scl_sync_ff;
   logic [2:0]                 sda_sync_ff;
   logic                       scl_ff;
   logic                       sda_ff;
   logic                       scl_d_ff;
   logic                       sda_d_ff;
   logic                       scl_rise;
   logic                       scl_fall;
   logic                       start_cond;
   logic                       stop_cond;
   amp_link_pkg::tgt_state_type state_ff;
   logic [3:0]                 bit_cnt_ff;
   logic [1:0]                 byte_num_ff;
   logic [7:0]                 shift_ff;
   logic [7:0]                 index_ff;
   logic                       rw_ff;
   logic                       nack_ff;
   logic                       sda_oe_ff;
   logic [5:0]                 latched_ff;
   logic [5:0]                 live_ff;
   logic                       fault_n_ff;
   logic [7:0]                 rd_data;
   logic                       wr_pulse;
   logic                       byte_done;

   // three-stage synchronisers, level taken once stages two and three agree
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
         scl_ff      <= 1'b1;
         sda_ff      <= 1'b1;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], LINK.scl};
         sda_sync_ff <= {sda_sync_ff[1:0], LINK.sda};
         if (scl_sync_ff[1] == scl_sync_ff[2]) scl_ff <= scl_sync_ff[2];
         if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
         scl_d_ff    <= scl_ff;
         sda_d_ff    <= sda_ff;
      end
   end

   // edge and condition detection
   assign scl_rise   = scl_ff & ~scl_d_ff;
   assign scl_fall   = ~scl_ff & scl_d_ff;
   assign start_cond = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
   assign stop_cond  = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;
   assign byte_done  = (state_ff == amp_link_pkg::T_RX) && scl_fall && (bit_cnt_ff == `BYTE_BITS);
   // third byte of a write is data
   assign wr_pulse   = byte_done && (byte_num_ff == 2'h2);

   // ----------------------------------------------------------------
   // register read view
   // ----------------------------------------------------------------
   // reserved bits read zero
   always_comb begin
      if (index_ff == `IDX_FAULTS) rd_data = {latched_ff, `RSVD_BITS};
      else if (index_ff == `IDX_STATE) rd_data = {live_ff, `RSVD_BITS};
      else rd_data = 8'h00;
   end

   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   // data line only, the clock is never driven
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_ff    <= amp_link_pkg::T_IDLE;
         bit_cnt_ff  <= 4'h0;
         byte_num_ff <= 2'h0;
         shift_ff    <= 8'h00;
         index_ff    <= 8'h00;
         rw_ff       <= 1'b0;
         nack_ff     <= 1'b0;
         sda_oe_ff   <= 1'b0;
      end else if (start_cond) begin
         state_ff    <= amp_link_pkg::T_RX;
         bit_cnt_ff  <= 4'h0;
         byte_num_ff <= 2'h0;
         sda_oe_ff   <= 1'b0;
      end else if (stop_cond) begin
         state_ff    <= amp_link_pkg::T_IDLE;
         sda_oe_ff   <= 1'b0;
      end else begin
         case (state_ff)
            amp_link_pkg::T_RX: begin
               if (scl_rise && bit_cnt_ff != `BYTE_BITS) begin
                  shift_ff   <= {shift_ff[6:0], sda_ff};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               if (byte_done) begin
                  bit_cnt_ff <= 4'h0;
                  if (byte_num_ff == 2'h0 && shift_ff[7:1] != `TGT_ADDR7) begin
                     // foreign address, wait for next start
                     state_ff <= amp_link_pkg::T_IDLE;
                  end else begin
                     sda_oe_ff <= 1'b1;
                     state_ff  <= amp_link_pkg::T_RACK;
                     if (byte_num_ff == 2'h0) rw_ff <= shift_ff[0];
                     if (byte_num_ff == 2'h1) index_ff <= shift_ff;
                  end
               end
            end
            amp_link_pkg::T_RACK: begin
               // ack held low until clock falls again
               if (scl_fall) begin
                  bit_cnt_ff <= 4'h0;
                  if (rw_ff == `DIR_READ && byte_num_ff == 2'h0) begin
                     state_ff  <= amp_link_pkg::T_TX;
                     shift_ff  <= rd_data;
                     sda_oe_ff <= ~rd_data[7];
                  end else begin
                     state_ff    <= amp_link_pkg::T_RX;
                     sda_oe_ff   <= 1'b0;
                     byte_num_ff <= (byte_num_ff == 2'h2) ? 2'h2 : byte_num_ff + 2'h1;
                  end
               end
            end
            amp_link_pkg::T_TX: begin
               // next bit placed after clock falls
               if (scl_fall) begin
                  if (bit_cnt_ff == `LAST_TX_BIT) begin
                     sda_oe_ff  <= 1'b0;
                     bit_cnt_ff <= 4'h0;
                     state_ff   <= amp_link_pkg::T_TACK;
                  end else begin
                     shift_ff   <= {shift_ff[6:0], 1'b0};
                     sda_oe_ff  <= ~shift_ff[6];
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            amp_link_pkg::T_TACK: begin
               if (scl_rise) nack_ff <= sda_ff;
               if (scl_fall) begin
                  if (nack_ff) begin
                     state_ff <= amp_link_pkg::T_IDLE;
                  end else begin
                     state_ff  <= amp_link_pkg::T_TX;
                     shift_ff  <= rd_data;
                     sda_oe_ff <= ~rd_data[7];
                  end
               end
            end
            default: begin
               state_ff  <= amp_link_pkg::T_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status registers
   // ----------------------------------------------------------------
   // latch fault events, write one clears, set wins
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         latched_ff <= 6'h00;
      end else if (wr_pulse && index_ff == `IDX_FAULTS) begin
         latched_ff <= (latched_ff & ~shift_ff[7:2]) | FAULT_EVENT_I;
      end else begin
         latched_ff <= latched_ff | FAULT_EVENT_I;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) live_ff <= 6'h00;
      else live_ff <= STATE_LIVE_I;
   end

   // pin asserted while any latched fault remains
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) fault_n_ff <= 1'b1;
      else fault_n_ff <= ~(|latched_ff);
   end

   assign FAULT_N_O        = fault_n_ff;
   assign LINK.dev_sda_out = 1'b0;
   assign LINK.dev_sda_oe  = sda_oe_ff;
endmodule : amp_status_target
`default_nettype wire

// File: amp_status_host.sv
// two-wire controller with AXI4-Lite command and status registers
`timescale 1ns/1ps
`default_nettype none
`include "amp_link_defs.svh"
module amp_status_host #(
   parameter int QTR = `QTR_CYCLES
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_N_I,
   amp_link_if.host_mp      LINK,
   input  wire logic [3:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   output logic [1:0]       S_AXI_BRESP_O,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   input  wire logic [3:0]  S_AXI_ARADDR_I,
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                     awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]               bresp_ff, rresp_ff;
   logic [31:0]              rdata_ff;
   logic [3:0]               awaddr_ff;
   logic [31:0]              wdata_ff;
   logic [3:0]               wstrb_ff;
   logic                     go;
   logic [2:0]               sda_sync_ff;
   logic                     sda_ff;
   logic [15:0]              qcnt_ff;
   logic                     tick;
   amp_link_pkg::host_op_type op_ff;
   amp_link_pkg::host_op_type nxt_op;
   logic [1:0]               ph_ff;
   logic [3:0]               bit_ff;
   logic [2:0]               step_ff;
   logic [2:0]               nxt_step;
   logic [7:0]               tx_ff, rx_ff, idx_ff, wd_ff, rd_ff;
   logic                     rw_ff, nack_ff, busy_ff, scl_oe_ff, sda_oe_ff, op_end;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // both write halves held, then one response
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
         awaddr_ff  <= 4'h0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
      end else begin
         if (S_AXI_AWVALID_I && awready_ff) begin
            awaddr_ff  <= S_AXI_AWADDR_I;
            awready_ff <= 1'b0;
         end
         if (S_AXI_WVALID_I && wready_ff) begin
            wdata_ff  <= S_AXI_WDATA_I;
            wstrb_ff  <= S_AXI_WSTRB_I;
            wready_ff <= 1'b0;
         end
         if (!awready_ff && !wready_ff && !bvalid_ff) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff == `CTRL_OFS || awaddr_ff == `STATUS_OFS) ?
                         `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_ff && S_AXI_BREADY_I) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // command accepted only while idle, ignored otherwise
   assign go = !awready_ff && !wready_ff && !bvalid_ff && awaddr_ff == `CTRL_OFS &&
               wstrb_ff[0] && wdata_ff[`CTRL_GO_BIT] && !busy_ff;

   // read channel: status shows busy, nack and last read byte
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= `RESP_OKAY;
      end else if (S_AXI_ARVALID_I && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= `RESP_OKAY;
         if (S_AXI_ARADDR_I == `CTRL_OFS) rdata_ff <= {8'h00, wd_ff, idx_ff, 6'h00, rw_ff, 1'b0};
         else if (S_AXI_ARADDR_I == `STATUS_OFS) rdata_ff <= {16'h0, rd_ff, 6'h00, nack_ff, busy_ff};
         else begin
            rdata_ff <= 32'h0;
            rresp_ff <= `RESP_SLVERR;
         end
      end else if (rvalid_ff && S_AXI_RREADY_I) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // link engine
   // ----------------------------------------------------------------
   // data line sampled through three stages
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         sda_sync_ff <= 3'h7;
         sda_ff      <= 1'b1;
      end else begin
         sda_sync_ff <= {sda_sync_ff[1:0], LINK.sda};
         if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
      end
   end

   // quarter-period divider for the serial clock
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) qcnt_ff <= 16'h0;
      else if (!busy_ff || tick) qcnt_ff <= 16'h0;
      else qcnt_ff <= qcnt_ff + 16'h1;
   end
   assign tick   = busy_ff && (qcnt_ff == 16'(QTR - 1));
   assign op_end = tick && ph_ff == 2'h3 &&
                   (op_ff == amp_link_pkg::H_START || op_ff == amp_link_pkg::H_STOP ||
                    bit_ff == `BYTE_BITS);

   // sequence: write S,addr,idx,data,P; read S,addr,idx,Sr,addr,byte,P
   always_comb begin
      nxt_step = step_ff + 3'h1;
      if (op_ff == amp_link_pkg::H_TXB && nack_ff) nxt_step = rw_ff ? 3'h6 : 3'h4;
      if (nxt_step == 3'h3 && rw_ff) nxt_op = amp_link_pkg::H_START;
      else if (nxt_step == 3'h5 && rw_ff) nxt_op = amp_link_pkg::H_RXB;
      else if (nxt_step == (rw_ff ? 3'h6 : 3'h4)) nxt_op = amp_link_pkg::H_STOP;
      else nxt_op = amp_link_pkg::H_TXB;
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         op_ff <= amp_link_pkg::H_IDLE;
         ph_ff <= 2'h0;  bit_ff <= 4'h0;  step_ff <= 3'h0;
         tx_ff <= 8'h00; rx_ff <= 8'h00;  idx_ff <= 8'h00;
         wd_ff <= 8'h00; rd_ff <= 8'h00;
         rw_ff <= 1'b0;  nack_ff <= 1'b0; busy_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else if (go) begin
         busy_ff <= 1'b1;
         rw_ff   <= wdata_ff[`CTRL_RW_BIT];
         if (wstrb_ff[1]) idx_ff <= wdata_ff[15:8];
         if (wstrb_ff[2]) wd_ff <= wdata_ff[23:16];
         nack_ff <= 1'b0;
         op_ff   <= amp_link_pkg::H_START;
         step_ff <= 3'h0;
         ph_ff   <= 2'h0;
      end else if (tick) begin
         ph_ff <= ph_ff + 2'h1;
         case (op_ff)
            amp_link_pkg::H_START: begin
               // release, raise clock, pull data, lower clock
               if (ph_ff == 2'h0) sda_oe_ff <= 1'b0;
               if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
               if (ph_ff == 2'h2) sda_oe_ff <= 1'b1;
               if (ph_ff == 2'h3) scl_oe_ff <= 1'b1;
            end
            amp_link_pkg::H_TXB, amp_link_pkg::H_RXB: begin
               // data set while clock is low, sampled while high
               if (ph_ff == 2'h0) sda_oe_ff <= (op_ff == amp_link_pkg::H_TXB) &&
                                               bit_ff != `BYTE_BITS && !tx_ff[7];
               if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
               if (ph_ff == 2'h2) begin
                  if (op_ff == amp_link_pkg::H_TXB && bit_ff == `BYTE_BITS) nack_ff <= sda_ff;
                  if (op_ff == amp_link_pkg::H_RXB && bit_ff != `BYTE_BITS)
                     rx_ff <= {rx_ff[6:0], sda_ff};
               end
               if (ph_ff == 2'h3) begin
                  scl_oe_ff <= 1'b1;
                  tx_ff     <= {tx_ff[6:0], 1'b0};
                  bit_ff    <= bit_ff + 4'h1;
               end
            end
            amp_link_pkg::H_STOP: begin
               if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
               if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
               if (ph_ff == 2'h2) sda_oe_ff <= 1'b0;
            end
            default: op_ff <= amp_link_pkg::H_IDLE;
         endcase
         if (op_end) begin
            bit_ff  <= 4'h0;
            step_ff <= nxt_step;
            if (op_ff == amp_link_pkg::H_STOP) begin
               op_ff   <= amp_link_pkg::H_IDLE;
               busy_ff <= 1'b0;
               rd_ff   <= rx_ff;
            end else begin
               op_ff <= nxt_op;
               if (nxt_step == 3'h1) tx_ff <= {`TGT_ADDR7, `DIR_WRITE};
               else if (nxt_step == 3'h2) tx_ff <= idx_ff;
               else if (nxt_step == 3'h3) tx_ff <= wd_ff;
               else tx_ff <= {`TGT_ADDR7, `DIR_READ};
            end
         end
      end
   end

   assign LINK.host_scl_out = 1'b0;
   assign LINK.host_scl_oe  = scl_oe_ff;
   assign LINK.host_sda_out = 1'b0;
   assign LINK.host_sda_oe  = sda_oe_ff;
   assign S_AXI_AWREADY_O   = awready_ff;
   assign S_AXI_WREADY_O    = wready_ff;
   assign S_AXI_BRESP_O     = bresp_ff;
   assign S_AXI_BVALID_O    = bvalid_ff;
   assign S_AXI_ARREADY_O   = arready_ff;
   assign S_AXI_RDATA_O     = rdata_ff;
   assign S_AXI_RRESP_O     = rresp_ff;
   assign S_AXI_RVALID_O    = rvalid_ff;
endmodule : amp_status_host
`default_nettype wire

// File: amp_link_sva.sv
// checker for the shared two-wire link lines
`timescale 1ns/1ps
`default_nettype none
`include "amp_link_defs.svh"
module amp_link_sva (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe
);
   logic       scl_q_ff, sda_q_ff, first_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff, adr_ff;
   wire logic  st_w   = scl && scl_q_ff && sda_q_ff && !sda;
   wire logic  rise_w = scl && !scl_q_ff;
   wire logic  ack_w  = rise_w && bit_ff == 4'h8;
   // previous line levels
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
      end
   end
   // bit count and byte capture since start
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         bit_ff   <= 4'h0;
         first_ff <= 1'b0;
         sh_ff    <= 8'h00;
         adr_ff   <= 8'h00;
      end else if (st_w) begin
         bit_ff   <= 4'h0;
         first_ff <= 1'b1;
      end else if (rise_w) begin
         bit_ff   <= ack_w ? 4'h0 : bit_ff + 4'h1;
         sh_ff    <= {sh_ff[6:0], sda};
         first_ff <= first_ff && !ack_w;
         adr_ff   <= (ack_w && first_ff) ? sh_ff : adr_ff;
      end
   end
   // --------
   // assertions
   // --------
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence start_s;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_s;
      scl && $past(scl) && $rose(sda);
   endsequence
   dev_moves_a : assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("target data moved in clock high");
   clk_high_a : assert property ($rose(scl) |-> scl [*8])
      else $error("clock high too short");
   clk_low_a : assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low too short");
   start_shape_a : assert property (start_s |-> scl [*4] ##1 !scl)
      else $error("bad start framing");
   start_free_a : assert property (start_s |=> !dev_sda_oe [*8])
      else $error("target holds data after start");
   stop_free_a : assert property (stop_s |=> !dev_sda_oe [*8])
      else $error("target holds data after stop");
   addr_ack_a : assert property (ack_w && first_ff |-> sda == (sh_ff[7:1] != `TGT_ADDR7))
      else $error("wrong address acknowledge");
   data_ack_a : assert property (ack_w && !first_ff && adr_ff == 8'hd8 |-> !sda)
      else $error("written byte not acknowledged");
endmodule : amp_link_sva
`default_nettype wire

// File: tb.sv
// self-checking bench joining controller and target
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk, rst_n, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, fault_n;
   logic [3:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [1:0]  br, rr;
   logic [5:0]  ev, live;
   logic [5:0]  tbl [3] = '{6'h01, 6'h2a, 6'h15};
   int          err_count, samples_checked, cyc;
   amp_link_if link ();
   amp_status_host #(.QTR(4)) amp_status_host_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .LINK(link), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
      .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara),
      .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry));
   amp_status_target amp_status_target_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .LINK(link), .FAULT_EVENT_I(ev), .STATE_LIVE_I(live), .FAULT_N_O(fault_n));
   amp_link_sva amp_link_sva_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .scl(link.scl),
      .sda(link.sda), .dev_sda_oe(link.dev_sda_oe));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL time=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bus write, waits for the response
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
      chk(br, er);
   endtask : axi_wr
   // bus read, waits for the data
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rry <= 1'b0;
      d = rd;
      r = rr;
   endtask : axi_rd
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] v;
      logic [1:0]  r;
      axi_rd(a, v, r);
      chk(v, exp);
      chk(r, er);
   endtask : rd_chk
   // one link transfer, then poll until idle
   task automatic link_op(input logic [7:0] idx, input logic [7:0] d, input logic rw,
                          input logic [7:0] exp);
      logic [31:0] st;
      logic [1:0]  r;
      axi_wr(4'h0, {8'h00, d, idx, 6'h00, rw, 1'b1}, 2'b00);
      st = 32'h1;
      while (st[0] !== 1'b0) axi_rd(4'h4, st, r);
      chk(st[1], 1'b0);
      if (rw) chk(st[15:8], exp);
   endtask : link_op
   task automatic final_report();
      $display("checked=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   // --------
   // clock, timeout and tests
   // --------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      {awv, wv, bry, arv, rry, awa, ara, wd, ev, live} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(fault_n, 1'b1);
      rd_chk(4'h4, 32'h0, 2'b00);
      rd_chk(4'h8, 32'h0, 2'b10);
      axi_wr(4'h8, 32'h0000_0101, 2'b10);
      ev <= 6'h3f;
      @(posedge clk);
      ev <= 6'h00;
      link_op(8'h01, 8'h00, 1'b1, 8'hfc);
      chk(fault_n, 1'b0);
      link_op(8'h01, 8'h87, 1'b0, 8'h00);
      link_op(8'h01, 8'h00, 1'b1, 8'h78);
      chk(fault_n, 1'b0);
      link_op(8'h01, 8'hff, 1'b0, 8'h00);
      link_op(8'h01, 8'h00, 1'b1, 8'h00);
      chk(fault_n, 1'b1);
      for (int i = 0; i < 3; i++) begin
         live <= tbl[i];
         link_op(8'h02, 8'hff, 1'b0, 8'h00);
         link_op(8'h02, 8'h00, 1'b1, {tbl[i], 2'b00});
         chk(fault_n, 1'b1);
      end
      link_op(8'h03, 8'h00, 1'b1, 8'h00);
      rd_chk(4'h0, 32'h0000_0302, 2'b00);
      final_report();
   end
endmodule : tb
`default_nettype wire
